//--- rtl/control_output_mode_driver.sv
// Turns loop percent outputs into switch and analog drive
`timescale 1ns/100ps
module control_output_mode_driver
   import ctl_out_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic sys_clk_in, // System clock, 200 MHz
   input wire logic nrst_in, // Async reset, active low
   input wire ctl_mode_t loop1_mode_in, // Requested loop one mode
   input wire ctl_mode_t loop2_mode_in, // Requested loop two mode
   input wire pct_t pct1_in, // Loop one percent output
   input wire pct_t pct2_in, // Loop two percent output
   input wire pct_t slide_pos_in, // Slidewire position 0..1000
   input wire dband_t deadband_sw_in, // Deadband switches, tenths
   input wire cyc_t cycle1_ms_in, // Loop one cycle time, ms
   input wire cyc_t cycle2_ms_in, // Loop two cycle time, ms
   output switch_t switch_out, // Output switches
   output analog_t analog_out, // Analog outputs, tenths of span
   output logic mode_refused_out, // Last mode request refused
   output logic loop2_analog_only_out // Loop two has no switch
);

   typedef struct packed {
      ctl_mode_t l1_mode;
      ctl_mode_t l2_mode;
      dband_t db_meta;
      dband_t db_sync;
      pct_t prev1;
      logic rev1;
      logic rev2;
      logic hy_fwd;
      logic hy_rev;
      logic mv_open;
      logic mv_close;
      logic refused;
      switch_t sw;
      analog_t ana;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic load1;
   logic load2;
   logic on1;
   logic on2;
   duty_t duty1;
   duty_t duty2;
   wide_t diff1;
   wide_t err;
   wide_t db;
   logic pp_full;
   logic pp_zero;
   logic dual2;
   logic l2_fwd;
   logic l2_rev;

   // Clamp a signed value into 0..full scale
   function automatic duty_t pos_part(input wide_t v);
      if (v <= 12'sh000) begin
         pos_part = '0;
      end else if (v >= 12'(PCT_FULL)) begin
         pos_part = duty_t'(PCT_FULL);
      end else begin
         pos_part = v[9:0];
      end
   endfunction

   function automatic duty_t mag(input wide_t v);
      mag = pos_part((v < 12'sh000) ? -v : v);
   endfunction

   // Loop one modes that leave a switch for loop two
   function automatic logic dual_form(input ctl_mode_t m);
      dual_form = (m == time_prop_single) || (m == bang_bang_single) ||
                  (m == time_prop_complement) || (m == bang_bang_complement);
   endfunction

   duty_slicer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) slice1 (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .cycle_ms_in(cycle1_ms_in),
      .duty_in(duty1),
      .load_out(load1),
      .on_out(on1)
   );

   duty_slicer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) slice2 (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .cycle_ms_in(cycle2_ms_in),
      .duty_in(duty2),
      .load_out(load2),
      .on_out(on2)
   );

   always_comb begin
      st_next = st_reg;

      // loop two may not take slidewire mode
      if (loop2_mode_in != motor_feedback_mode) begin
         st_next.l2_mode = loop2_mode_in;
      end
      // loop one may not take multi-resource
      if (loop1_mode_in != multi_resource_mode) begin
         st_next.l1_mode = loop1_mode_in;
      end
      st_next.refused = (loop1_mode_in == multi_resource_mode) ||
                        (loop2_mode_in == motor_feedback_mode);

      // Switches are asynchronous to the clock
      st_next.db_meta = deadband_sw_in;
      st_next.db_sync = st_reg.db_meta;
      if (st_reg.db_sync < DB_MIN) begin
         db = 12'(DB_MIN);
      end else if (st_reg.db_sync > DB_MAX) begin
         db = 12'(DB_MAX);
      end else begin
         db = 12'(st_reg.db_sync);
      end

      diff1 = 12'(pct1_in) - 12'(st_reg.prev1);
      pp_full = pct1_in >= PCT_FULL;
      pp_zero = pct1_in <= 11'sh000;

      unique case (st_reg.l1_mode)
         time_prop_single, time_prop_complement: duty1 = pos_part(12'(pct1_in));
         dual_time_prop: duty1 = mag(12'(pct1_in));
         position_bump_mode: duty1 = (pp_full || pp_zero) ? duty_t'(PCT_FULL) : mag(diff1);
         default: duty1 = '0;
      endcase
      duty2 = mag(12'(pct2_in));

      // direction and history at cycle start
      if (load1) begin
         st_next.prev1 = pct1_in;
         if (st_reg.l1_mode == position_bump_mode) begin
            st_next.rev1 = pp_zero || (!pp_full && diff1 < 12'sh000);
         end else begin
            st_next.rev1 = pct1_in < 11'sh000;
         end
      end
      if (load2) begin
         st_next.rev2 = pct2_in < 11'sh000;
      end

      if (pct1_in >= ON_TH) begin
         st_next.hy_fwd = 1'b1;
      end else if (pct1_in <= OFF_TH) begin
         st_next.hy_fwd = 1'b0;
      end
      if (pct1_in <= -ON_TH) begin
         st_next.hy_rev = 1'b1;
      end else if (pct1_in >= -OFF_TH) begin
         st_next.hy_rev = 1'b0;
      end

      err = 12'(pct1_in) - 12'(slide_pos_in);
      st_next.mv_open = err > db;
      st_next.mv_close = -err > db;

      // loop two dual with one switch
      dual2 = (st_reg.l2_mode == multi_resource_mode) && dual_form(st_reg.l1_mode);
      l2_fwd = dual2 && on2 && !st_reg.rev2;
      l2_rev = dual2 && on2 && st_reg.rev2;

      st_next.sw = '0;
      unique case (st_reg.l1_mode)
         // second switch lent to loop two
         time_prop_single: begin
            st_next.sw.ctl1 = on1;
            st_next.sw.ctl2 = l2_rev;
         end
         time_prop_complement: begin
            st_next.sw.ctl1 = on1;
            st_next.sw.ctl2 = !on1;
         end
         dual_time_prop, position_bump_mode: begin
            st_next.sw.ctl1 = on1 && !st_reg.rev1;
            st_next.sw.ctl2 = on1 && st_reg.rev1;
         end
         motor_feedback_mode: begin
            st_next.sw.ctl1 = st_reg.mv_open;
            st_next.sw.ctl2 = st_reg.mv_close && !st_reg.mv_open;
         end
         bang_bang_single: begin
            st_next.sw.ctl1 = st_reg.hy_fwd;
            st_next.sw.ctl2 = l2_rev;
         end
         bang_bang_complement: begin
            st_next.sw.ctl1 = st_reg.hy_fwd;
            st_next.sw.ctl2 = !st_reg.hy_fwd;
         end
         bang_bang_dual: begin
            st_next.sw.ctl1 = st_reg.hy_fwd;
            st_next.sw.ctl2 = st_reg.hy_rev;
         end
         default: st_next.sw = '0;
      endcase
      // event three is loop two forward
      if (st_reg.l1_mode == time_prop_complement || st_reg.l1_mode == bang_bang_complement) begin
         st_next.sw.event3 = l2_fwd;
      end

      st_next.ana.aout1 = pos_part(12'(pct2_in));
      st_next.ana.aout2 = dual2 ? pos_part(-12'(pct2_in)) : '0;
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '{l1_mode: MODE_RST, l2_mode: MODE_RST, db_meta: DB_RST,
                     db_sync: DB_RST, prev1: '0, rev1: 1'b0, rev2: 1'b0,
                     hy_fwd: 1'b0, hy_rev: 1'b0, mv_open: 1'b0, mv_close: 1'b0,
                     refused: 1'b0, sw: '0, ana: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign switch_out = st_reg.sw;
   assign analog_out = st_reg.ana;
   assign mode_refused_out = st_reg.refused;
   // no switch for loop two beside a dual loop one
   assign loop2_analog_only_out = (st_reg.l2_mode == multi_resource_mode) &&
                                  !dual_form(st_reg.l1_mode);

   tp_single_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ($past(st_reg.l1_mode) == time_prop_single && $past(st_reg.l2_mode) != multi_resource_mode)
      |-> !switch_out.ctl2 && !switch_out.event3)
      else $error("single time-prop drove a second switch");

   tc_inverse_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $past(st_reg.l1_mode) == time_prop_complement |-> switch_out.ctl2 == !switch_out.ctl1)
      else $error("complement output not inverse");

   dual_excl_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !$past(dual_form(st_reg.l1_mode)) |-> !(switch_out.ctl1 && switch_out.ctl2))
      else $error("both direction outputs on");

   loop1_refuse_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      loop1_mode_in == multi_resource_mode
      |=> st_reg.l1_mode == $past(st_reg.l1_mode) && mode_refused_out)
      else $error("loop one took multi-resource mode");

   loop2_refuse_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      loop2_mode_in == motor_feedback_mode
      |=> st_reg.l2_mode == $past(st_reg.l2_mode) && mode_refused_out)
      else $error("loop two took slidewire mode");

   onoff_on_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st_reg.l1_mode == bang_bang_single && pct1_in >= ON_TH) ##1
      (st_reg.l1_mode == bang_bang_single) |=> switch_out.ctl1)
      else $error("on/off did not turn on at threshold");

   onoff_hold_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st_reg.hy_fwd && pct1_in > OFF_TH) |=> st_reg.hy_fwd)
      else $error("on/off dropped above turn-off level");

   rev_hyst_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (pct1_in <= -ON_TH |=> st_reg.hy_rev) and (pct1_in >= -OFF_TH |=> !st_reg.hy_rev))
      else $error("reverse on/off thresholds wrong");

   oc_inverse_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $past(st_reg.l1_mode) == bang_bang_complement |-> switch_out.ctl2 != switch_out.ctl1)
      else $error("complement on/off not inverse");

   motor_dead_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st_reg.l1_mode == motor_feedback_mode && err <= db && -err <= db) ##1
      (st_reg.l1_mode == motor_feedback_mode) |=> (!switch_out.ctl1 && !switch_out.ctl2))
      else $error("motor driven inside deadband");

   mm_analog_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      loop2_analog_only_out |=> !switch_out.event3 && analog_out.aout2 == '0)
      else $error("loop two got a switch beside a dual loop one");

endmodule

//--- rtl/ctl_out_pkg.sv
// Shared types and constants for the control output mode driver
package ctl_out_pkg;

   // Output modes of a control loop
   typedef enum logic [3:0] {
      time_prop_single,
      time_prop_complement,
      dual_time_prop,
      motor_feedback_mode,
      position_bump_mode,
      bang_bang_single,
      bang_bang_complement,
      bang_bang_dual,
      multi_resource_mode
   } ctl_mode_t;

   // Percent output in tenths of a percent, -1000 .. +1000
   typedef logic signed [10:0] pct_t;
   typedef logic signed [11:0] wide_t;
   typedef logic [9:0] duty_t;
   typedef logic [15:0] cyc_t;
   typedef logic [6:0] dband_t;

   typedef struct packed {
      logic ctl1;
      logic ctl2;
      logic event3;
   } switch_t;

   typedef struct packed {
      duty_t aout1;
      duty_t aout2;
   } analog_t;

   localparam pct_t PCT_FULL = 11'sh3E8;
   localparam pct_t ON_TH = 11'sh064;
   localparam pct_t OFF_TH = 11'sh014;
   localparam dband_t DB_MIN = 7'h02;
   localparam dband_t DB_MAX = 7'h64;

   // Cycle time runs in 1 ms ticks
   localparam int CLK_NS = 5;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_NS;
   localparam int PRE_W = 24;

   localparam ctl_mode_t MODE_RST = time_prop_single;
   localparam duty_t DUTY_RST = 10'h000;
   localparam dband_t DB_RST = 7'h02;

endpackage

//--- rtl/duty_slicer.sv
// Proportioning cycle timer that slices one cycle by a latched duty
`timescale 1ns/100ps
module duty_slicer
   import ctl_out_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic sys_clk_in, // System clock
   input wire logic nrst_in, // Async reset, active low
   input wire cyc_t cycle_ms_in, // Cycle time in ms
   input wire duty_t duty_in, // Duty in tenths of percent
   output logic load_out, // Cycle start, duty taken
   output logic on_out // Sliced on-time
);

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      cyc_t elapsed;
      duty_t duty;
      logic primed;
      logic on;
   } slice_t;

   slice_t st_reg;
   slice_t st_next;
   logic tick;
   logic last;
   logic [25:0] lhs;
   logic [25:0] rhs;

   always_comb begin
      st_next = st_reg;
      tick = (st_reg.pre == PRE_W'(TICK_CYCLES - 1));
      // Zero cycle time acts as one tick
      last = tick && ({1'b0, st_reg.elapsed} + 17'h00001 >= {1'b0, cycle_ms_in});
      load_out = !st_reg.primed || last;
      st_next.pre = tick ? '0 : st_reg.pre + 1'b1;
      if (load_out) begin
         st_next.pre = '0;
         st_next.elapsed = '0;
         st_next.duty = duty_in;
         st_next.primed = 1'b1;
      end else if (tick) begin
         st_next.elapsed = st_reg.elapsed + 16'h0001;
      end
      // on for duty share of cycle
      // Judged on the next state, so on-time and the latched direction share one edge
      lhs = 26'(st_next.elapsed) * 26'(PCT_FULL);
      rhs = 26'(st_next.duty) * 26'(cycle_ms_in);
      st_next.on = lhs < rhs;
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '{pre: '0, elapsed: '0, duty: DUTY_RST, primed: 1'b0, on: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign on_out = st_reg.on;

   duty_hold_a: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !load_out |=> st_reg.duty == $past(st_reg.duty))
      else $error("duty changed inside a cycle");

endmodule

//--- dv/pid_stub.sv
// Stand-in for the loop computation that feeds percent outputs
`timescale 1ns/100ps
module pid_stub
   import ctl_out_pkg::*;
(
   input wire pct_t err1_in, // Loop one error, tenths
   input wire pct_t err2_in, // Loop two error, tenths
   output pct_t pct1_out, // Loop one percent output
   output pct_t pct2_out // Loop two percent output
);
   function automatic pct_t limit(input pct_t v);
      if (v > PCT_FULL) return PCT_FULL;
      if (v < -PCT_FULL) return -PCT_FULL;
      return v;
   endfunction

   // proportional only, no I or D
   always_comb begin
      pct1_out = limit(err1_in);
      pct2_out = limit(err2_in);
   end
endmodule

//--- dv/control_output_mode_driver_test.sv
// Self-checking bench for the control output mode driver
`timescale 1ns/100ps
module control_output_mode_driver_test;
   import ctl_out_pkg::*;
   localparam int TK = 4;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   ctl_mode_t m1 = time_prop_single;
   ctl_mode_t m2 = time_prop_single;
   pct_t e1 = 11'sh000;
   pct_t e2 = 11'sh000;
   pct_t slide = 11'sh1F4;
   pct_t p1;
   pct_t p2;
   dband_t db = 7'h02;
   cyc_t cyc1 = 16'h000A;
   switch_t sw;
   analog_t an;
   logic refused;
   logic aonly;
   int error_cnt = 0;
   int compares = 0;
   logic [31:0] n1, n2, n3, nb;

   always #2.5 sys_clk_in = ~sys_clk_in;

   pid_stub i_pid (.err1_in(e1), .err2_in(e2), .pct1_out(p1), .pct2_out(p2));

   control_output_mode_driver #(.TICK_CYCLES(TK)) i_dut (
      .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .loop1_mode_in(m1), .loop2_mode_in(m2),
      .pct1_in(p1), .pct2_in(p2), .slide_pos_in(slide), .deadband_sw_in(db),
      .cycle1_ms_in(cyc1), .cycle2_ms_in(16'h000A), .switch_out(sw), .analog_out(an),
      .mode_refused_out(refused), .loop2_analog_only_out(aonly));

   task automatic go(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   task automatic chk_sig(input logic [19:0] got, input logic [19:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t count got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Window of 40 clocks is exactly one 10 ms cycle, so phase does not matter
   task automatic count(input int n);
      n1 = 0; n2 = 0; n3 = 0; nb = 0;
      repeat (n) begin
         @(negedge sys_clk_in);
         // Unknown switch levels poison the sums instead of counting as off
         n1 = n1 + 32'(sw.ctl1);
         n2 = n2 + 32'(sw.ctl2);
         n3 = n3 + 32'(sw.event3);
         nb = nb + 32'(sw.ctl1 & sw.ctl2);
      end
   endtask

   task automatic setup(input ctl_mode_t a, input ctl_mode_t b, input pct_t x, input pct_t y);
      m1 = a; m2 = b; e1 = x; e2 = y;
      go(100);
   endtask

   task automatic t_time_prop();
      setup(time_prop_single, time_prop_single, 11'sh154, 11'sh000);
      count(40);
      chk_cnt(n1, 16);
      chk_cnt(n2, 0);
      setup(time_prop_complement, time_prop_single, 11'sh154, 11'sh000);
      count(40);
      chk_cnt(n1, 16);
      chk_cnt(n2, 24);
      chk_cnt(nb, 0);
      setup(dual_time_prop, time_prop_single, -11'sh1F4, 11'sh000);
      count(40);
      chk_cnt(n1, 0);
      chk_cnt(n2, 20);
      e1 = 11'sh3E8;
      count(120);
      chk_cnt(nb, 0);
      cyc1 = 16'h0005;
      setup(time_prop_single, time_prop_single, 11'sh154, 11'sh000);
      count(20);
      chk_cnt(n1, 8);
      cyc1 = 16'h000A;
   endtask

   task automatic t_refuse();
      setup(bang_bang_single, time_prop_single, 11'sh064, 11'sh000);
      m1 = multi_resource_mode;
      go(2);
      chk_sig(refused, 1'b1);
      go(2);
      chk_sig(sw, 3'b100);
      m1 = bang_bang_single;
      m2 = motor_feedback_mode;
      go(2);
      chk_sig(refused, 1'b1);
      m2 = time_prop_single;
      go(3);
      chk_sig(refused, 1'b0);
   endtask

   task automatic onoff(input pct_t v, input logic [2:0] exp);
      e1 = v;
      go(4);
      chk_sig(sw, exp);
   endtask

   task automatic t_onoff();
      setup(bang_bang_single, time_prop_single, 11'sh000, 11'sh000);
      onoff(11'sh063, 3'b000);
      onoff(11'sh064, 3'b100);
      onoff(11'sh015, 3'b100);
      onoff(11'sh014, 3'b000);
      m1 = bang_bang_complement;
      onoff(11'sh064, 3'b100);
      onoff(11'sh014, 3'b010);
      m1 = bang_bang_dual;
      onoff(-11'sh063, 3'b000);
      onoff(-11'sh064, 3'b010);
      onoff(-11'sh015, 3'b010);
      onoff(-11'sh014, 3'b000);
      onoff(11'sh064, 3'b100);
   endtask

   task automatic t_motor();
      db = 7'h0A;
      setup(motor_feedback_mode, time_prop_single, 11'sh1FF, 11'sh000);
      chk_sig(sw, 3'b100);
      onoff(11'sh1FE, 3'b000);
      onoff(11'sh1EA, 3'b000);
      onoff(11'sh1E9, 3'b010);
   endtask

   task automatic t_bump();
      setup(position_bump_mode, time_prop_single, 11'sh1C2, 11'sh000);
      e1 = 11'sh258;
      count(120);
      chk_cnt(n1, 8);
      chk_cnt(n2, 0);
      e1 = 11'sh1C2;
      count(120);
      chk_cnt(n2, 8);
      setup(position_bump_mode, time_prop_single, 11'sh3E8, 11'sh000);
      count(40);
      chk_cnt(n1, 40);
      setup(position_bump_mode, time_prop_single, 11'sh000, 11'sh000);
      count(40);
      chk_cnt(n2, 40);
   endtask

   task automatic t_multi();
      setup(bang_bang_single, multi_resource_mode, 11'sh000, -11'sh1F4);
      count(40);
      chk_cnt(n2, 20);
      chk_sig(aonly, 1'b0);
      chk_sig(an, {10'h000, 10'h1F4});
      setup(time_prop_complement, multi_resource_mode, 11'sh000, 11'sh12C);
      count(40);
      chk_cnt(n3, 12);
      chk_sig(an, {10'h12C, 10'h000});
      setup(dual_time_prop, multi_resource_mode, 11'sh000, -11'sh12C);
      count(40);
      chk_cnt(n3 + n2, 0);
      chk_sig(aonly, 1'b1);
      chk_sig(an, 20'h00000);
   endtask

   task automatic end_of_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end

   initial begin
      go(3);
      chk_sig({sw, refused, aonly}, 5'h00);
      chk_sig(an, 20'h00000);
      nrst_in = 1'b1;
      t_time_prop();
      t_refuse();
      t_onoff();
      t_motor();
      t_bump();
      t_multi();
      end_of_test();
   end
endmodule
